/* File: verilog/eblpm_pkg.sv */
// Constants for the low external-bus pin multiplexer: register map, fields, resets.
// Assumes a 32-bit AXI4-Lite slave with byte addresses in the low eight bits.
//
// Summary of operation
// - When port_b_line0 is not an address pin, software sets it as a GPIO input or output.
// - In bus role port_b_line0 carries addr_line_16 of external memory accesses.
// - With the bus idle, addr_line_16 and the memory control outputs float or stay driven per bus_drive_select.
// - After reset port_b_line0 starts as GPIO or address from boot select, interface mode and flash security.
// - A software write to port_b_periph_enable overrides the reset choice in every case.
// - Clearing bit 0 of port_b_pullup_enable turns the port_b_line0 pull-up off.
// - Data lines 0 to 6 carry part of the external memory data word during bus accesses.
// - With the bus idle, data lines 0 to 6 float or stay driven per bus_drive_select.
// - Each port F line 9 to 15 is set on its own as a GPIO input or output.
// - At reset the seven port F pins default to the external memory data function.
// - Clearing port_f_pullup_enable bit n turns off the pull-up of port F line n.
package eblpm_pkg;

    // ========================================================================
    // Bus geometry
    localparam int          ADDR_W      = 8;
    localparam int          PF_W        = 7;
    localparam int          PF_LO       = 9;
    localparam int          PF_HI       = 15;
    localparam int          SYNC_STAGES = 2;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ========================================================================
    // Register byte offsets
    localparam logic [7:0]  EXT_BUS_CONTROL_OFF = 8'h00;
    localparam logic [7:0]  PB_PERIPH_OFF       = 8'h04;
    localparam logic [7:0]  PB_PULLUP_OFF       = 8'h08;
    localparam logic [7:0]  PB_DIR_OFF          = 8'h0c;
    localparam logic [7:0]  PB_DATA_OFF         = 8'h10;
    localparam logic [7:0]  PB_PIN_OFF          = 8'h14;
    localparam logic [7:0]  PF_PERIPH_OFF       = 8'h18;
    localparam logic [7:0]  PF_PULLUP_OFF       = 8'h1c;
    localparam logic [7:0]  PF_DIR_OFF          = 8'h20;
    localparam logic [7:0]  PF_DATA_OFF         = 8'h24;
    localparam logic [7:0]  PF_PIN_OFF          = 8'h28;
    localparam logic [7:0]  STATUS_OFF          = 8'h2c;

    // ========================================================================
    // Field positions
    localparam int          BUS_DRIVE_SELECT_BIT = 0;
    localparam int          PORT_B_LINE0_BIT     = 0;
    localparam int          ST_BUS_ACTIVE_BIT    = 0;
    localparam int          ST_BOOT_BIT          = 1;
    localparam int          ST_MODE_BIT          = 2;
    localparam int          ST_SECURE_BIT        = 3;
    localparam int          ST_LOADED_BIT        = 4;

    // ========================================================================
    // Reset values
    localparam logic        BUS_DRIVE_RST = 1'b0;
    localparam logic        PB_PERIPH_RST = 1'b0;
    localparam logic        PB_PULLUP_RST = 1'b1;
    localparam logic        PB_DIR_RST    = 1'b0;
    localparam logic        PB_DATA_RST   = 1'b0;
    localparam logic [6:0]  PF_PERIPH_RST = 7'h7f;
    localparam logic [6:0]  PF_PULLUP_RST = 7'h7f;
    localparam logic [6:0]  PF_DIR_RST    = 7'h00;
    localparam logic [6:0]  PF_DATA_RST   = 7'h00;

endpackage : eblpm_pkg

/* File: verilog/eblpm_sync.sv */
// Two-stage synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous levels; no reset, data only.
`timescale 1ns/1ns
`default_nettype none
module eblpm_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         ce,
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);

    logic [W-1:0] meta_reg;

    // ========================================================================
    // Stage one feeds stage two only
    always_ff @(posedge clk) begin
        if (ce) begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : eblpm_sync
`default_nettype wire

/* File: verilog/eblpm_pad_sel.sv */
// Per-pad function select: bus function or general-purpose I/O.
// Assumes all inputs are on the system clock; the caller registers the outputs.
`timescale 1ns/1ns
`default_nettype none
module eblpm_pad_sel #(
    parameter int W = 1
) (
    input  wire logic [W-1:0] periph_sel,
    input  wire logic [W-1:0] gpio_out,
    input  wire logic [W-1:0] gpio_dir,
    input  wire logic [W-1:0] bus_out,
    input  wire logic [W-1:0] bus_oe,
    output wire logic [W-1:0] pad_out,
    output wire logic [W-1:0] pad_oe
);

    // ========================================================================
    // Bitwise choice between bus and GPIO paths
    assign pad_out = (periph_sel & bus_out) | (~periph_sel & gpio_out);
    assign pad_oe  = (periph_sel & bus_oe)  | (~periph_sel & gpio_dir);

endmodule : eblpm_pad_sel
`default_nettype wire

/* File: verilog/eblpm_top.sv */
// Pin mux for addr_line_16 / port_b_line0 and data lines 0..6 / port F lines 9..15.
// Assumes an AXI4-Lite master on clk, and an external memory interface on clk.
`timescale 1ns/1ns
`default_nettype none
module eblpm_top (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        ce,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        external_boot_select,
    input  wire logic        ext_interface_mode_input,
    input  wire logic        flash_secure,
    input  wire logic        emi_bus_active,
    input  wire logic        emi_addr16,
    input  wire logic [6:0]  emi_data_out,
    input  wire logic        emi_data_oe,
    output var  logic [6:0]  emi_data_in,
    output var  logic        emi_ctrl_oe,
    input  wire logic        port_b_line0_in,
    output var  logic        port_b_line0_out,
    output var  logic        port_b_line0_oe,
    output var  logic        port_b_line0_pullup,
    input  wire logic [6:0]  port_f_in,
    output var  logic [6:0]  port_f_out,
    output var  logic [6:0]  port_f_oe,
    output var  logic [6:0]  port_f_pullup
);

    // ========================================================================
    // Helpers
    function automatic logic [31:0] wr_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  ws);
        logic [31:0] m;
        m = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
        return (old & ~m) | (wd & m);
    endfunction : wr_merge

    function automatic logic strap_addr_mode(input logic boot, input logic mode,
                                             input logic secure);
        return boot | (mode & ~secure);
    endfunction : strap_addr_mode

    // ========================================================================
    // State
    logic        drv_reg;
    logic        pb_per_reg;
    logic        pb_pur_reg;
    logic        pb_dir_reg;
    logic        pb_dat_reg;
    logic [6:0]  pf_per_reg;
    logic [6:0]  pf_pur_reg;
    logic [6:0]  pf_dir_reg;
    logic [6:0]  pf_dat_reg;
    logic        strap_loaded_reg;
    logic        aw_got_reg;
    logic        w_got_reg;
    logic [7:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic [10:0] sync_bus;

    // ========================================================================
    // Pin synchronisers
    eblpm_sync #(.W(11)) u_sync (
        .clk      (clk),
        .ce       (ce),
        .async_in ({flash_secure, ext_interface_mode_input, external_boot_select,
                    port_f_in, port_b_line0_in}),
        .sync_out (sync_bus)
    );

    wire       pb_in_s  = sync_bus[0];
    wire [6:0] pf_in_s  = sync_bus[7:1];
    wire       boot_s   = sync_bus[8];
    wire       mode_s   = sync_bus[9];
    wire       secure_s = sync_bus[10];

    // ========================================================================
    // AXI4-Lite write path
    wire        aw_hs     = s_axi_awvalid & s_axi_awready;
    wire        w_hs      = s_axi_wvalid & s_axi_wready;
    wire        aw_have   = aw_got_reg | aw_hs;
    wire        w_have    = w_got_reg | w_hs;
    wire        do_write  = aw_have & w_have;
    wire [7:0]  waddr     = aw_hs ? s_axi_awaddr : awaddr_reg;
    wire [31:0] wdat      = w_hs ? s_axi_wdata : wdata_reg;
    wire [3:0]  wstb      = w_hs ? s_axi_wstrb : wstrb_reg;
    wire [7:0]  waddr_al  = {waddr[7:2], 2'b00};
    wire        bvalid_nx = do_write | (s_axi_bvalid & ~s_axi_bready);

    // Write decode per register
    wire wr_bcr    = do_write & (waddr_al == eblpm_pkg::EXT_BUS_CONTROL_OFF);
    wire wr_pb_per = do_write & (waddr_al == eblpm_pkg::PB_PERIPH_OFF);
    wire wr_pb_pur = do_write & (waddr_al == eblpm_pkg::PB_PULLUP_OFF);
    wire wr_pb_dir = do_write & (waddr_al == eblpm_pkg::PB_DIR_OFF);
    wire wr_pb_dat = do_write & (waddr_al == eblpm_pkg::PB_DATA_OFF);
    wire wr_pf_per = do_write & (waddr_al == eblpm_pkg::PF_PERIPH_OFF);
    wire wr_pf_pur = do_write & (waddr_al == eblpm_pkg::PF_PULLUP_OFF);
    wire wr_pf_dir = do_write & (waddr_al == eblpm_pkg::PF_DIR_OFF);
    wire wr_pf_dat = do_write & (waddr_al == eblpm_pkg::PF_DATA_OFF);
    wire wr_ok     = wr_bcr | wr_pb_per | wr_pb_pur | wr_pb_dir | wr_pb_dat |
                     wr_pf_per | wr_pf_pur | wr_pf_dir | wr_pf_dat;

    // Merged write words, current value in the documented bit positions
    wire [31:0] m_bcr = wr_merge({31'h0, drv_reg}, wdat, wstb);
    wire [31:0] m_pbp = wr_merge({31'h0, pb_per_reg}, wdat, wstb);
    wire [31:0] m_pbu = wr_merge({31'h0, pb_pur_reg}, wdat, wstb);
    wire [31:0] m_pbd = wr_merge({31'h0, pb_dir_reg}, wdat, wstb);
    wire [31:0] m_pbo = wr_merge({31'h0, pb_dat_reg}, wdat, wstb);
    wire [31:0] m_pfp = wr_merge({16'h0, pf_per_reg, 9'h0}, wdat, wstb);
    wire [31:0] m_pfu = wr_merge({16'h0, pf_pur_reg, 9'h0}, wdat, wstb);
    wire [31:0] m_pfd = wr_merge({16'h0, pf_dir_reg, 9'h0}, wdat, wstb);
    wire [31:0] m_pfo = wr_merge({16'h0, pf_dat_reg, 9'h0}, wdat, wstb);

    // Handshake flags and held address/data
    always_ff @(posedge clk) begin
        if (reset) begin
            aw_got_reg    <= 1'b0;
            w_got_reg     <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= eblpm_pkg::RESP_OKAY;
            awaddr_reg    <= 8'h00;
            wdata_reg     <= 32'h0;
            wstrb_reg     <= 4'h0;
        end else if (ce) begin
            aw_got_reg    <= aw_have & ~do_write;
            w_got_reg     <= w_have & ~do_write;
            s_axi_awready <= ~bvalid_nx & ~(aw_have & ~do_write);
            s_axi_wready  <= ~bvalid_nx & ~(w_have & ~do_write);
            s_axi_bvalid  <= bvalid_nx;
            if (aw_hs) awaddr_reg <= s_axi_awaddr;
            if (w_hs) begin
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end
            if (do_write) s_axi_bresp <= wr_ok ? eblpm_pkg::RESP_OKAY
                                               : eblpm_pkg::RESP_SLVERR;
        end
    end

    // ========================================================================
    // Control registers
    wire strap_load = ~strap_loaded_reg;
    wire strap_mode = strap_addr_mode(boot_s, mode_s, secure_s);

    always_ff @(posedge clk) begin
        if (reset) begin
            drv_reg          <= eblpm_pkg::BUS_DRIVE_RST;
            pb_per_reg       <= eblpm_pkg::PB_PERIPH_RST;
            pb_pur_reg       <= eblpm_pkg::PB_PULLUP_RST;
            pb_dir_reg       <= eblpm_pkg::PB_DIR_RST;
            pb_dat_reg       <= eblpm_pkg::PB_DATA_RST;
            pf_per_reg       <= eblpm_pkg::PF_PERIPH_RST;
            pf_pur_reg       <= eblpm_pkg::PF_PULLUP_RST;
            pf_dir_reg       <= eblpm_pkg::PF_DIR_RST;
            pf_dat_reg       <= eblpm_pkg::PF_DATA_RST;
            strap_loaded_reg <= 1'b0;
        end else if (ce) begin
            strap_loaded_reg <= 1'b1;
            if (wr_bcr) drv_reg <= m_bcr[eblpm_pkg::BUS_DRIVE_SELECT_BIT];
            // Software write beats the strap choice
            if (wr_pb_per) pb_per_reg <= m_pbp[eblpm_pkg::PORT_B_LINE0_BIT];
            else if (strap_load) pb_per_reg <= strap_mode;
            if (wr_pb_pur) pb_pur_reg <= m_pbu[eblpm_pkg::PORT_B_LINE0_BIT];
            if (wr_pb_dir) pb_dir_reg <= m_pbd[eblpm_pkg::PORT_B_LINE0_BIT];
            if (wr_pb_dat) pb_dat_reg <= m_pbo[eblpm_pkg::PORT_B_LINE0_BIT];
            if (wr_pf_per) pf_per_reg <= m_pfp[eblpm_pkg::PF_HI:eblpm_pkg::PF_LO];
            if (wr_pf_pur) pf_pur_reg <= m_pfu[eblpm_pkg::PF_HI:eblpm_pkg::PF_LO];
            if (wr_pf_dir) pf_dir_reg <= m_pfd[eblpm_pkg::PF_HI:eblpm_pkg::PF_LO];
            if (wr_pf_dat) pf_dat_reg <= m_pfo[eblpm_pkg::PF_HI:eblpm_pkg::PF_LO];
        end
    end

    // ========================================================================
    // AXI4-Lite read path
    wire       ar_hs     = s_axi_arvalid & s_axi_arready;
    wire       rvalid_nx = ar_hs | (s_axi_rvalid & ~s_axi_rready);
    wire [7:0] raddr_al  = {s_axi_araddr[7:2], 2'b00};
    logic [31:0] rd_word;
    logic        rd_hit;

    // Read mux, port F fields at bits 15..9
    always_comb begin
        rd_word = 32'h0;
        rd_hit  = 1'b1;
        case (raddr_al)
            eblpm_pkg::EXT_BUS_CONTROL_OFF: rd_word = {31'h0, drv_reg};
            eblpm_pkg::PB_PERIPH_OFF:       rd_word = {31'h0, pb_per_reg};
            eblpm_pkg::PB_PULLUP_OFF:       rd_word = {31'h0, pb_pur_reg};
            eblpm_pkg::PB_DIR_OFF:          rd_word = {31'h0, pb_dir_reg};
            eblpm_pkg::PB_DATA_OFF:         rd_word = {31'h0, pb_dat_reg};
            eblpm_pkg::PB_PIN_OFF:          rd_word = {31'h0, pb_in_s};
            eblpm_pkg::PF_PERIPH_OFF:       rd_word = {16'h0, pf_per_reg, 9'h0};
            eblpm_pkg::PF_PULLUP_OFF:       rd_word = {16'h0, pf_pur_reg, 9'h0};
            eblpm_pkg::PF_DIR_OFF:          rd_word = {16'h0, pf_dir_reg, 9'h0};
            eblpm_pkg::PF_DATA_OFF:         rd_word = {16'h0, pf_dat_reg, 9'h0};
            eblpm_pkg::PF_PIN_OFF:          rd_word = {16'h0, pf_in_s, 9'h0};
            eblpm_pkg::STATUS_OFF:          rd_word = {27'h0, strap_loaded_reg, secure_s,
                                                       mode_s, boot_s, emi_bus_active};
            default:                        rd_hit  = 1'b0;
        endcase
    end

    // Read response register
    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= eblpm_pkg::RESP_OKAY;
        end else if (ce) begin
            s_axi_arready <= ~rvalid_nx;
            s_axi_rvalid  <= rvalid_nx;
            if (ar_hs) begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? eblpm_pkg::RESP_OKAY : eblpm_pkg::RESP_SLVERR;
            end
        end
    end

    // ========================================================================
    // Pad function select
    wire       pb_bus_oe = emi_bus_active | drv_reg;
    wire [6:0] pf_bus_oe = emi_bus_active ? {7{emi_data_oe}} : {7{drv_reg}};
    wire       pb_out_c;
    wire       pb_oe_c;
    wire [6:0] pf_out_c;
    wire [6:0] pf_oe_c;

    eblpm_pad_sel #(.W(1)) u_pad_b (
        .periph_sel (pb_per_reg),
        .gpio_out   (pb_dat_reg),
        .gpio_dir   (pb_dir_reg),
        .bus_out    (emi_addr16),
        .bus_oe     (pb_bus_oe),
        .pad_out    (pb_out_c),
        .pad_oe     (pb_oe_c)
    );

    eblpm_pad_sel #(.W(7)) u_pad_f (
        .periph_sel (pf_per_reg),
        .gpio_out   (pf_dat_reg),
        .gpio_dir   (pf_dir_reg),
        .bus_out    (emi_data_out),
        .bus_oe     (pf_bus_oe),
        .pad_out    (pf_out_c),
        .pad_oe     (pf_oe_c)
    );

    // Registered pad drives; reset floats outputs with pull-ups on
    always_ff @(posedge clk) begin
        if (reset) begin
            port_b_line0_out    <= 1'b0;
            port_b_line0_oe     <= 1'b0;
            port_b_line0_pullup <= eblpm_pkg::PB_PULLUP_RST;
            port_f_out          <= 7'h00;
            port_f_oe           <= 7'h00;
            port_f_pullup       <= eblpm_pkg::PF_PULLUP_RST;
            emi_data_in         <= 7'h00;
            emi_ctrl_oe         <= 1'b0;
        end else if (ce) begin
            port_b_line0_out    <= pb_out_c;
            port_b_line0_oe     <= pb_oe_c;
            port_b_line0_pullup <= pb_pur_reg;
            port_f_out          <= pf_out_c;
            port_f_oe           <= pf_oe_c;
            port_f_pullup       <= pf_pur_reg;
            emi_data_in         <= pf_in_s;
            emi_ctrl_oe         <= pb_bus_oe;
        end
    end

    // ========================================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Clock-enable history for the checks; left free-running on purpose
    logic ce_d1_reg;
    logic ce_d2_reg;

    always_ff @(posedge clk) begin
        ce_d1_reg <= ce;
        ce_d2_reg <= ce_d1_reg;
    end

    wire ce_hist = ce_d1_reg & ce_d2_reg;

    chk_pb_gpio_dir: assert property (ce_hist & ~$past(pb_per_reg) |->
        port_b_line0_oe == $past(pb_dir_reg) && port_b_line0_out == $past(pb_dat_reg))
        else $error("port_b_line0 GPIO drive mismatch");
    chk_pb_addr_out: assert property (ce_hist & $past(pb_per_reg) |->
        port_b_line0_out == $past(emi_addr16))
        else $error("addr_line_16 not on port_b_line0");
    chk_pb_idle_float: assert property (ce_hist & $past(pb_per_reg & ~emi_bus_active &
        ~drv_reg) |-> !port_b_line0_oe && !emi_ctrl_oe)
        else $error("addr_line_16 driven while idle without drive select");
    chk_strap_load: assert property ($rose(strap_loaded_reg) && !$past(wr_pb_per) |->
        pb_per_reg == $past(strap_mode))
        else $error("strap choice not loaded");
    chk_per_override: assert property (ce & wr_pb_per & wstb[0] |=>
        pb_per_reg == wdat[0])
        else $error("port_b_periph_enable write lost");
    chk_pb_pullup: assert property (ce_hist |-> port_b_line0_pullup == $past(pb_pur_reg))
        else $error("port_b_line0 pull-up mismatch");
    chk_data_bus: assert property (ce_hist & $past(emi_bus_active) |->
        ((port_f_oe ^ {7{$past(emi_data_oe)}}) & $past(pf_per_reg)) == 7'h00)
        else $error("data line drive mismatch during access");
    chk_data_idle: assert property (ce_hist & $past(~emi_bus_active & ~drv_reg) |->
        (port_f_oe & $past(pf_per_reg)) == 7'h00)
        else $error("data line driven while idle");
    chk_pf_gpio_dir: assert property (ce_hist |->
        (port_f_oe & ~$past(pf_per_reg)) == ($past(pf_dir_reg) & ~$past(pf_per_reg)))
        else $error("port F GPIO direction mismatch");
    chk_pf_reset_bus: assert property ($fell(reset) |-> pf_per_reg == 7'h7f)
        else $error("port F not in data mode after reset");
    chk_pf_pullup: assert property (ce_hist |-> port_f_pullup == $past(pf_pur_reg))
        else $error("port F pull-up mismatch");
    chk_reset_pads: assert property (@(posedge clk) disable iff (1'b0) reset |=>
        !port_b_line0_oe && port_f_oe == 7'h00 && port_b_line0_pullup && port_f_pullup == 7'h7f)
        else $error("pads not safe during reset");

    cov_addr_access: cover property (pb_per_reg & emi_bus_active ##1 port_b_line0_oe);
    cov_per_write:   cover property (wr_pb_per ##1 s_axi_bvalid & s_axi_bready);
    cov_gpio_drive:  cover property (~pf_per_reg[0] & pf_dir_reg[0] ##1 port_f_oe[0]);
    cov_read_back:   cover property (ar_hs ##1 s_axi_rvalid & s_axi_rready);

endmodule : eblpm_top
`default_nettype wire

/* File: tb/eblpm_mem_model.sv */
// External memory model on the data pins of port F lines 9..15.
// Assumes mux pad outputs on clk; read data and read phase come from the bench.
`timescale 1ns/1ns
`default_nettype none
module eblpm_mem_model (
    input  wire logic       clk,
    input  wire logic       mem_rd,
    input  wire logic [6:0] mem_q,
    input  wire logic [6:0] pad_out,
    input  wire logic [6:0] pad_oe,
    input  wire logic [6:0] pad_pu,
    output var  logic [6:0] pin
);
    logic [6:0] last_pin = 7'h00;
    // ========================================================================
    // Pin level: mux drive, memory drive, pull-up, else toggling
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            if (pad_oe[i]) pin[i] = pad_out[i];
            else if (mem_rd) pin[i] = mem_q[i];
            else if (pad_pu[i]) pin[i] = 1'b1;
            else pin[i] = ~last_pin[i];
        end
    end
    // Last level, inverted when floating
    always @(posedge clk) last_pin <= pin;
endmodule : eblpm_mem_model
`default_nettype wire

/* File: tb/tb_ext_bus_low_pin_mux.sv */
// Bench for the low external-bus pin mux: AXI register tasks and pad checks.
// Assumes eblpm_top and the memory model; one 125 MHz clock.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
    $display("FAIL %0t got %h exp %h", $time, a, b); end end
module tb_ext_bus_low_pin_mux;
    logic clk = 0, reset = 1, ce = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, emi_ctrl_oe, port_b_line0_out, port_b_line0_oe;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic external_boot_select = 0, ext_interface_mode_input = 1, flash_secure = 0;
    logic emi_bus_active = 0, emi_addr16 = 0, emi_data_oe = 0, port_b_line0_in = 1, mem_rd = 0;
    logic [6:0] emi_data_out = 0, mem_q = 0, emi_data_in, port_f_in, port_f_out, port_f_oe;
    logic [6:0] port_f_pullup;
    logic port_b_line0_pullup;
    int failures = 0, samples_checked = 0;
    eblpm_top dut (.*);
    eblpm_mem_model mem (.clk(clk), .mem_rd(mem_rd), .mem_q(mem_q), .pad_out(port_f_out),
        .pad_oe(port_f_oe), .pad_pu(port_f_pullup), .pin(port_f_in));
    // ========================================================================
    // Clock and bus tasks
    initial forever #4 clk = ~clk;
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask : wt
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n = 0;
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge clk); n++;
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_bvalid !== 1'b1 && n < 40);
        s_axi_bready <= 0;
        if (s_axi_bvalid !== 1'b1) begin
            failures++;
            $display("FAIL %0t write timeout", $time);
        end
        `CHK(s_axi_bresp, r)
        @(posedge clk);
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n = 0;
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do begin
            @(posedge clk); n++;
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (s_axi_rvalid !== 1'b1 && n < 40);
        s_axi_rready <= 0;
        if (s_axi_rvalid !== 1'b1) begin
            failures++;
            $display("FAIL %0t read timeout", $time);
        end
        `CHK(s_axi_rdata, d)
        `CHK(s_axi_rresp, r)
        @(posedge clk);
    endtask : axi_rd
    // ========================================================================
    // Scenarios
    task automatic t_reset;
        wt(16);
        `CHK({port_b_line0_oe, port_f_oe, port_b_line0_pullup, port_f_pullup}, 16'h00ff)
        reset <= 0; wt(3);
        axi_rd(8'h04, 32'h1, 2'h0);
        axi_rd(8'h18, 32'hfe00, 2'h0);
        axi_rd(8'h1c, 32'hfe00, 2'h0);
    endtask : t_reset
    task automatic t_bus;
        emi_bus_active <= 1; emi_addr16 <= 1; emi_data_oe <= 1; emi_data_out <= 7'h55; wt(3);
        `CHK({port_b_line0_oe, port_b_line0_out}, 2'h3)
        `CHK({port_f_oe, port_f_out}, 14'h3fd5)
        emi_data_oe <= 0; mem_rd <= 1; mem_q <= 7'h2a; wt(6);
        `CHK(emi_data_in, 7'h2a)
        emi_bus_active <= 0; mem_rd <= 0; wt(3);
        `CHK({port_b_line0_oe, port_f_oe, emi_ctrl_oe}, 9'h000)
        axi_wr(8'h00, 32'h1, 2'h0); wt(3);
        `CHK({port_b_line0_oe, port_f_oe, emi_ctrl_oe}, 9'h1ff)
        `CHK(port_f_out, 7'h55)
        axi_wr(8'h00, 32'h0, 2'h0);
    endtask : t_bus
    task automatic t_gpio;
        axi_wr(8'h04, 32'h0, 2'h0); axi_wr(8'h0c, 32'h1, 2'h0);
        axi_wr(8'h10, 32'h1, 2'h0); wt(3);
        `CHK({port_b_line0_oe, port_b_line0_out}, 2'h3)
        axi_wr(8'h0c, 32'h0, 2'h0); port_b_line0_in <= 0; wt(4);
        axi_rd(8'h14, 32'h0, 2'h0);
        axi_wr(8'h08, 32'h0, 2'h0); wt(3);
        `CHK(port_b_line0_pullup, 1'b0)
        axi_wr(8'h18, 32'hfc00, 2'h0); axi_wr(8'h20, 32'h200, 2'h0);
        axi_wr(8'h24, 32'h200, 2'h0); wt(3);
        `CHK({port_f_oe, port_f_out[0]}, 8'h03)
        axi_wr(8'h1c, 32'hfc00, 2'h0); wt(3);
        `CHK(port_f_pullup, 7'h7e)
        axi_wr(8'h14, 32'h1, 2'h2);
        axi_rd(8'h30, 32'h0, 2'h2);
    endtask : t_gpio
    // Mid-run reset with flash secured: strap picks GPIO
    task automatic t_strap;
        flash_secure <= 1; reset <= 1; wt(4);
        reset <= 0; wt(3);
        axi_rd(8'h04, 32'h0, 2'h0);
        axi_rd(8'h2c, 32'h1c, 2'h0);
    endtask : t_strap
    // ========================================================================
    // Verdict, main sequence and watchdog
    task automatic results;
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    initial begin
        t_reset(); t_bus(); t_gpio(); t_strap(); results();
    end
    initial begin
        wt(5000); failures++; results();
    end
endmodule : tb_ext_bus_low_pin_mux
`default_nettype wire
